// File: rtl/trig_qual_pkg.sv
// Package: register map, field enumerations and state of the trigger block
package trig_qual_pkg;

  localparam int        DATA_W        = 32;
  localparam int        NUM_SRC       = 4;
  localparam int        NUM_EXT       = 4;
  localparam int        CNT_W         = 16;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFF     = 8'h00;
  localparam logic [7:0] LEVEL_OFF    = 8'h04;
  localparam logic [7:0] HYST_OFF     = 8'h08;
  localparam logic [7:0] BITS_OFF     = 8'h0c;
  localparam logic [7:0] MASK_OFF     = 8'h10;
  localparam logic [7:0] PMIN_OFF     = 8'h14;
  localparam logic [7:0] PMAX_OFF     = 8'h18;
  localparam logic [7:0] HOLD_OFF     = 8'h1c;
  localparam logic [7:0] IRQ_STAT_OFF = 8'h20;
  localparam logic [7:0] IRQ_MASK_OFF = 8'h24;
  localparam logic [7:0] STATE_OFF    = 8'h28;

  // CTRL field positions
  localparam int        MODE_LSB      = 0;
  localparam int        SRC_LSB       = 4;
  localparam int        EDGE_LSB      = 8;
  localparam int        PTYPE_LSB     = 10;
  localparam int        EXT_LSB       = 12;
  localparam int        LPF_EN_BIT    = 14;
  localparam int        LPF_SH_LSB    = 16;

  // Reset values
  localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
  localparam logic [31:0] ZERO_RST    = 32'h0000_0000;
  localparam logic [31:0] MASK_RST    = 32'hffff_ffff;

  // Interrupt status bits
  localparam int        IRQ_TRIG_BIT  = 0;
  localparam int        IRQ_QUAL_BIT  = 1;

  typedef enum logic [2:0] {
    MODE_CONT, MODE_EDGE, MODE_DIGITAL, MODE_PULSE,
    MODE_TRACK_EDGE, MODE_TRACK_PULSE, MODE_EXT
  } mode_type;

  typedef enum logic [1:0] {
    DIR_RISE, DIR_FALL, DIR_BOTH
  } dir_type;

  typedef enum logic [1:0] {
    PULSE_IDLE, PULSE_HIGH, PULSE_LOW
  } pulse_state_type;

  // One streamed sample set
  typedef struct packed {
    logic                            valid;
    logic [NUM_SRC-1:0][DATA_W-1:0]  analog;
    logic [DATA_W-1:0]               lines;
  } sample_type;

  typedef struct packed {
    logic [31:0]       ctrl;
    logic [31:0]       level;
    logic [31:0]       hyst;
    logic [31:0]       bits;
    logic [31:0]       mask;
    logic [31:0]       pmin;
    logic [31:0]       pmax;
    logic [31:0]       hold;
    logic [1:0]        irq_stat;
    logic [1:0]        irq_mask;
    logic              a_sel;
    logic              a_write;
    logic [7:0]        a_addr;
    logic [31:0]       rdata;
    logic              match_prev;
    logic              armed_hi;
    logic              armed_lo;
    logic signed [31:0] filt;
    logic signed [31:0] track;
    pulse_state_type   pst;
    logic [31:0]       pwidth;
    logic [31:0]       hold_cnt;
    logic [2:0]        ext0;
    logic [2:0]        ext1;
    logic [2:0]        ext2;
    logic [2:0]        ext3;
    logic              ext_prev;
    logic              trig;
    logic              irq;
  } state_type;

endpackage

// File: rtl/acquisition_trigger_qualifier.sv
// Trigger qualifier: mode select, edge, digital, pulse, tracking, external
//
// Functional notes
// - Selectable trigger mode, seven kinds
// - Any one streamed signal is the source
// - Digital mode compares masked 32-bit lines
// - Digital trigger on first masked equality
// - Mask bit n maps to line n
// - Full 32-bit reference, all masked bits match
// - Effective value is reference AND mask
// - Edge uses level thresholds, hysteresis, filter
// - Edge direction rising, falling or both
// - Pulse width within minimum and maximum
// - Pulse polarity positive, negative or both
// - Tracking edge follows drift via filter
// - Tracking pulse qualifies width, follows drift
// - External trigger from one of four
// - Hysteresis side follows edge direction
// - Switchable filter, data path untouched
// - Hold-off count skips qualified triggers
//
// Chosen here: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
module acquisition_trigger_qualifier (
  // Clock, reset, enable
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  input  wire logic                       clk_en,
  // AHB-Lite slave
  input  wire logic                       hsel,
  input  wire logic [31:0]                haddr,
  input  wire logic [1:0]                 htrans,
  input  wire logic                       hwrite,
  input  wire logic [2:0]                 hsize,
  input  wire logic [31:0]                hwdata,
  input  wire logic                       hready,
  output      logic [31:0]                hrdata,
  output      logic                       hreadyout,
  output      logic                       hresp,
  // Streamed samples
  input  wire trig_qual_pkg::sample_type  sample,
  // External trigger pins, asynchronous
  input  wire logic [3:0]                 external_input_trigger,
  // Results
  output      logic                       trig_event,
  output      logic                       ext_state,
  output      logic                       irq
);

  trig_qual_pkg::state_type s_reg;
  trig_qual_pkg::state_type s_next;

  // Control fields
  trig_qual_pkg::mode_type mode;
  trig_qual_pkg::dir_type  dir;
  trig_qual_pkg::dir_type  ptype;
  logic [1:0]              src_sel;
  logic [1:0]              ext_sel;
  logic                    lpf_en;
  logic [4:0]              lpf_sh;
  logic signed [31:0]      raw;
  logic signed [31:0]      cmp_src;
  logic signed [31:0]      lvl;
  logic signed [31:0]      hy;
  logic                    above_hi;
  logic                    below_lo;
  logic                    rise_x;
  logic                    fall_x;
  logic                    match_now;
  logic                    pulse_ok;
  logic                    qual;
  logic                    pass;
  logic [3:0]              ext_sync;
  logic [3:0]              ext_mid;
  logic                    ext_now;

  assign mode    = trig_qual_pkg::mode_type'(s_reg.ctrl[trig_qual_pkg::MODE_LSB +: 3]);
  assign src_sel = s_reg.ctrl[trig_qual_pkg::SRC_LSB +: 2];
  assign dir     = trig_qual_pkg::dir_type'(s_reg.ctrl[trig_qual_pkg::EDGE_LSB +: 2]);
  assign ptype   = trig_qual_pkg::dir_type'(s_reg.ctrl[trig_qual_pkg::PTYPE_LSB +: 2]);
  assign ext_sel = s_reg.ctrl[trig_qual_pkg::EXT_LSB +: 2];
  assign lpf_en  = s_reg.ctrl[trig_qual_pkg::LPF_EN_BIT];
  assign lpf_sh  = s_reg.ctrl[trig_qual_pkg::LPF_SH_LSB +: 5];

  // Masked digital compare, shared by both sides of the equality
  function automatic logic [31:0] masked(input logic [31:0] v,
                                         input logic [31:0] m);
    masked = v & m;
  endfunction

  // Qualifier combinational path
  always_comb begin
    raw = $signed(sample.analog[src_sel]);
    // Filter feeds only the comparator; recorded data untouched
    cmp_src = lpf_en && (mode == trig_qual_pkg::MODE_EDGE ||
              mode == trig_qual_pkg::MODE_PULSE) ? s_reg.filt : raw;
    // Tracking modes compare against the slow filtered baseline
    lvl = (mode == trig_qual_pkg::MODE_TRACK_EDGE ||
           mode == trig_qual_pkg::MODE_TRACK_PULSE) ?
          s_reg.track + $signed(s_reg.level) : $signed(s_reg.level);
    hy  = $signed(s_reg.hyst);
    // Thresholds placed per direction
    above_hi = (dir == trig_qual_pkg::DIR_RISE) ? cmp_src >= lvl :
               cmp_src >= lvl + hy;
    below_lo = (dir == trig_qual_pkg::DIR_FALL) ? cmp_src <= lvl :
               cmp_src <= lvl - hy;
    rise_x = s_reg.armed_lo && above_hi;
    fall_x = s_reg.armed_hi && below_lo;
    match_now = masked(sample.lines, s_reg.mask) ==
                masked(s_reg.bits, s_reg.mask);
    // A pin change counts only once the last two stages agree
    ext_sync = {s_reg.ext3[2], s_reg.ext2[2], s_reg.ext1[2], s_reg.ext0[2]};
    ext_mid  = {s_reg.ext3[1], s_reg.ext2[1], s_reg.ext1[1], s_reg.ext0[1]};
    ext_now  = (ext_sync[ext_sel] == ext_mid[ext_sel]) ?
               ext_sync[ext_sel] : s_reg.ext_prev;
    pulse_ok = s_reg.pwidth >= s_reg.pmin && s_reg.pwidth <= s_reg.pmax;
    qual = 1'b0;
    unique case (mode)
      trig_qual_pkg::MODE_CONT:    qual = 1'b1;
      trig_qual_pkg::MODE_DIGITAL: qual = match_now && !s_reg.match_prev;
      trig_qual_pkg::MODE_EDGE,
      trig_qual_pkg::MODE_TRACK_EDGE:
        qual = (dir != trig_qual_pkg::DIR_FALL && rise_x) ||
               (dir != trig_qual_pkg::DIR_RISE && fall_x);
      trig_qual_pkg::MODE_PULSE,
      trig_qual_pkg::MODE_TRACK_PULSE:
        qual = pulse_ok &&
               ((s_reg.pst == trig_qual_pkg::PULSE_HIGH && fall_x &&
                 ptype != trig_qual_pkg::DIR_FALL) ||
                (s_reg.pst == trig_qual_pkg::PULSE_LOW && rise_x &&
                 ptype != trig_qual_pkg::DIR_RISE));
      trig_qual_pkg::MODE_EXT:     qual = ext_now && !s_reg.ext_prev;
      default:                     qual = 1'b0;
    endcase
    // External pins are not tied to the sample strobe
    qual = qual && (sample.valid || mode == trig_qual_pkg::MODE_EXT);
    pass = qual && (s_reg.hold_cnt == 32'h0000_0000);
  end

  // Next-state: bus, qualifier history, interrupts
  always_comb begin
    s_next = s_reg;
    s_next.trig = 1'b0;
    // Pin synchronisers, three stages each
    s_next.ext0 = {s_reg.ext0[1:0], external_input_trigger[0]};
    s_next.ext1 = {s_reg.ext1[1:0], external_input_trigger[1]};
    s_next.ext2 = {s_reg.ext2[1:0], external_input_trigger[2]};
    s_next.ext3 = {s_reg.ext3[1:0], external_input_trigger[3]};
    s_next.ext_prev = ext_now;
    if (sample.valid) begin
      s_next.match_prev = match_now;
      if (above_hi) s_next.armed_hi = 1'b1;
      if (below_lo) s_next.armed_lo = 1'b1;
      if (rise_x) s_next.armed_lo = 1'b0;
      if (fall_x) s_next.armed_hi = 1'b0;
      // First-order low-pass, shift sets the bandwidth
      s_next.filt  = s_reg.filt + ((raw - s_reg.filt) >>> lpf_sh);
      s_next.track = s_reg.track + ((raw - s_reg.track) >>> lpf_sh);
      // Each crossing closes one excursion and opens the next,
      // so a negative pulse is seen right after a positive one
      if (rise_x) begin
        s_next.pst    = trig_qual_pkg::PULSE_HIGH;
        s_next.pwidth = 32'h0000_0001;
      end else if (fall_x) begin
        s_next.pst    = trig_qual_pkg::PULSE_LOW;
        s_next.pwidth = 32'h0000_0001;
      end else if (s_reg.pst != trig_qual_pkg::PULSE_IDLE) begin
        s_next.pwidth = s_reg.pwidth + 32'h0000_0001;
      end
    end
    // Hold-off counting of skipped triggers
    if (qual) begin
      s_next.hold_cnt = pass ? s_reg.hold : s_reg.hold_cnt - 32'h0000_0001;
    end
    s_next.trig = pass;
    // Bus address phase capture
    if (hready) begin
      s_next.a_sel   = hsel && htrans[1];
      s_next.a_write = hwrite;
      s_next.a_addr  = haddr[7:0];
    end
    // Data phase write
    if (s_reg.a_sel && s_reg.a_write) begin
      unique case (s_reg.a_addr)
        trig_qual_pkg::CTRL_OFF:  s_next.ctrl  = hwdata;
        trig_qual_pkg::LEVEL_OFF: s_next.level = hwdata;
        trig_qual_pkg::HYST_OFF:  s_next.hyst  = hwdata;
        trig_qual_pkg::BITS_OFF:  s_next.bits  = hwdata;
        trig_qual_pkg::MASK_OFF:  s_next.mask  = hwdata;
        trig_qual_pkg::PMIN_OFF:  s_next.pmin  = hwdata;
        trig_qual_pkg::PMAX_OFF:  s_next.pmax  = hwdata;
        trig_qual_pkg::HOLD_OFF: begin
          s_next.hold     = hwdata;
          s_next.hold_cnt = 32'h0000_0000;
        end
        trig_qual_pkg::IRQ_STAT_OFF:
          s_next.irq_stat = s_reg.irq_stat & ~hwdata[1:0];
        trig_qual_pkg::IRQ_MASK_OFF: s_next.irq_mask = hwdata[1:0];
        default: ;
      endcase
    end
    // Event sets win over a same-cycle clear
    if (pass) s_next.irq_stat[trig_qual_pkg::IRQ_TRIG_BIT] = 1'b1;
    if (qual) s_next.irq_stat[trig_qual_pkg::IRQ_QUAL_BIT] = 1'b1;
    s_next.irq = |(s_next.irq_stat & s_next.irq_mask);
    // Read data registered for the data phase
    s_next.rdata = 32'h0000_0000;
    if (hready && hsel && htrans[1] && !hwrite) begin
      unique case (haddr[7:0])
        trig_qual_pkg::CTRL_OFF:     s_next.rdata = s_next.ctrl;
        trig_qual_pkg::LEVEL_OFF:    s_next.rdata = s_next.level;
        trig_qual_pkg::HYST_OFF:     s_next.rdata = s_next.hyst;
        trig_qual_pkg::BITS_OFF:     s_next.rdata = s_next.bits;
        trig_qual_pkg::MASK_OFF:     s_next.rdata = s_next.mask;
        trig_qual_pkg::PMIN_OFF:     s_next.rdata = s_next.pmin;
        trig_qual_pkg::PMAX_OFF:     s_next.rdata = s_next.pmax;
        trig_qual_pkg::HOLD_OFF:     s_next.rdata = s_next.hold;
        trig_qual_pkg::IRQ_STAT_OFF: s_next.rdata = {30'h0, s_next.irq_stat};
        trig_qual_pkg::IRQ_MASK_OFF: s_next.rdata = {30'h0, s_next.irq_mask};
        trig_qual_pkg::STATE_OFF:
          s_next.rdata = {28'h0, s_next.pst, s_next.match_prev,
                          s_next.ext_prev};
        default:                     s_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  // State register; clock enable freezes everything
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg      <= '0;
      s_reg.mask <= trig_qual_pkg::MASK_RST;
      s_reg.pst  <= trig_qual_pkg::PULSE_IDLE;
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end

  assign hrdata     = s_reg.rdata;
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign trig_event = s_reg.trig;
  assign ext_state  = s_reg.ext_prev;
  assign irq        = s_reg.irq;

  // Trigger falls after one cycle unless the next trigger also passes
  property p_trig_single;
    @(posedge hclk) disable iff (!hresetn)
      clk_en && trig_event |=> !trig_event || $past(pass);
  endproperty
  a_trig_single: assert property (p_trig_single) else $error("trigger not pulse");

  property p_cont_every;
    @(posedge hclk) disable iff (!hresetn)
      clk_en && mode == trig_qual_pkg::MODE_CONT && sample.valid &&
      s_reg.hold == 32'h0 && s_reg.hold_cnt == 32'h0 |=> trig_event;
  endproperty
  a_cont_every: assert property (p_cont_every) else $error("continuous missed");

  property p_dig_edge;
    @(posedge hclk) disable iff (!hresetn)
      clk_en && mode == trig_qual_pkg::MODE_DIGITAL && qual |->
      match_now && !s_reg.match_prev;
  endproperty
  a_dig_edge: assert property (p_dig_edge) else $error("digital edge wrong");

  property p_match_prev;
    @(posedge hclk) disable iff (!hresetn)
      clk_en && sample.valid |=> s_reg.match_prev == $past(match_now);
  endproperty
  a_match_prev: assert property (p_match_prev) else $error("history lost");

  property p_hold_skip;
    @(posedge hclk) disable iff (!hresetn)
      clk_en && qual && s_reg.hold_cnt != 32'h0 |=> !trig_event;
  endproperty
  a_hold_skip: assert property (p_hold_skip) else $error("hold-off ignored");

  property p_pulse_width;
    @(posedge hclk) disable iff (!hresetn)
      pass && (mode == trig_qual_pkg::MODE_PULSE) |->
      s_reg.pwidth >= s_reg.pmin && s_reg.pwidth <= s_reg.pmax;
  endproperty
  a_pulse_width: assert property (p_pulse_width) else $error("pulse width bad");

  property p_irq_level;
    @(posedge hclk) disable iff (!hresetn)
      ##1 irq == |$past(s_next.irq_stat & s_next.irq_mask);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq level wrong");

  property p_ext_rise;
    @(posedge hclk) disable iff (!hresetn)
      clk_en && mode == trig_qual_pkg::MODE_EXT && qual |-> ext_now && !ext_state;
  endproperty
  a_ext_rise: assert property (p_ext_rise) else $error("external edge wrong");

  // A passed external trigger leaves the monitored state high
  property p_ext_seen;
    @(posedge hclk) disable iff (!hresetn)
      clk_en && mode == trig_qual_pkg::MODE_EXT && qual |=> ext_state;
  endproperty
  a_ext_seen: assert property (p_ext_seen) else $error("external state lost");

  // Rising-only edge mode never fires on a falling crossing
  property p_edge_rise;
    @(posedge hclk) disable iff (!hresetn)
      clk_en && mode == trig_qual_pkg::MODE_EDGE &&
      dir == trig_qual_pkg::DIR_RISE && qual |-> rise_x && !fall_x;
  endproperty
  a_edge_rise: assert property (p_edge_rise) else $error("edge direction");

  // No sample strobe, no analog or digital trigger
  property p_idle_quiet;
    @(posedge hclk) disable iff (!hresetn)
      clk_en && !sample.valid && mode != trig_qual_pkg::MODE_EXT
      |=> !trig_event;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("trigger w/o sample");

  // Below the hysteresis band the rising edge is re-armed
  property p_hyst_arm;
    @(posedge hclk) disable iff (!hresetn)
      clk_en && mode == trig_qual_pkg::MODE_EDGE &&
      dir == trig_qual_pkg::DIR_RISE && sample.valid && below_lo
      |=> s_reg.armed_lo;
  endproperty
  a_hyst_arm: assert property (p_hyst_arm) else $error("hysteresis arm");

  c_digital: cover property (@(posedge hclk) mode == trig_qual_pkg::MODE_DIGITAL && trig_event);
  c_edge:    cover property (@(posedge hclk) mode == trig_qual_pkg::MODE_EDGE && trig_event);
  c_pulse:   cover property (@(posedge hclk) mode == trig_qual_pkg::MODE_PULSE && trig_event);
  c_ext:     cover property (@(posedge hclk) mode == trig_qual_pkg::MODE_EXT && trig_event);

endmodule

// File: bench/sample_source.sv
// Streamed sample source model feeding the trigger qualifier
`timescale 1ns/1ps
module sample_source (
  // Clock
  input  wire logic                 hclk,
  // Samples towards the qualifier
  output trig_qual_pkg::sample_type sample
);
  trig_qual_pkg::sample_type q[$];
  int                        gap_q[$];
  int                        gap;

  initial begin
    sample = '0;
    gap = 0;
  end

  // Queue one sample; unselected sources carry the inverse as a decoy
  task automatic send(input logic [31:0] a, input logic [31:0] l,
                      input int src, input int g);
    trig_qual_pkg::sample_type s;
    s.valid = 1'b1;
    for (int k = 0; k < trig_qual_pkg::NUM_SRC; k++) begin
      s.analog[k] = (k == src) ? a : ~a;
    end
    s.lines = l;
    q.push_back(s);
    gap_q.push_back(g);
  endtask

  function automatic bit busy();
    return q.size() != 0;
  endfunction

  // Idle cycles scramble the data so stale values never look valid
  always @(posedge hclk) begin
    if (gap == 0 && q.size() != 0) begin
      sample <= q.pop_front();
      gap = gap_q.pop_front();
    end else begin
      if (gap > 0) gap--;
      sample.valid  <= 1'b0;
      sample.analog <= ~sample.analog;
      sample.lines  <= ~sample.lines;
    end
  end
endmodule

// File: bench/tb_top.sv
// Self-checking testbench for the acquisition trigger qualifier
`timescale 1ns/1ps
module tb_top;
  logic                      hclk;
  logic                      hresetn;
  logic                      clk_en;
  logic                      hsel;
  logic [31:0]               haddr;
  logic [1:0]                htrans;
  logic                      hwrite;
  logic [2:0]                hsize;
  logic [31:0]               hwdata;
  logic [31:0]               hrdata;
  logic                      hreadyout;
  trig_qual_pkg::sample_type sample;
  logic [3:0]                ext_pins;
  logic                      trig_event;
  logic                      ext_state;
  logic                      irq;
  int                        errors;
  int                        n_tests;
  int                        seed;
  int                        sent;
  int                        idx;
  logic                      rd_pend;
  logic [31:0]               rd_q[$];
  int                        trig_q[$];
  logic [31:0]               b;
  logic [31:0]               m;
  logic [31:0]               l;
  logic                      mt;
  logic                      prev;
  logic [31:0]               seq[3][6] = '{'{0, 100, 45, 100, 0, 100},
                                           '{100, 0, 55, 0, 100, 0},
                                           '{0, 100, 0, 100, 55, 0}};
  logic [5:0]                hit[3] = '{6'b100010, 6'b100010, 6'b101110};
  int                        wd[3] = '{1, 4, 8};

  acquisition_trigger_qualifier acquisition_trigger_qualifier_inst (
    .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(), .sample(sample),
    .external_input_trigger(ext_pins), .trig_event(trig_event),
    .ext_state(ext_state), .irq(irq));

  sample_source sample_source_inst (.hclk(hclk), .sample(sample));

  // Clock
  always #10 hclk = ~hclk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // One single word transfer; a read notes its expected data
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wr ? d : 32'h0;
    if (!wr) rd_q.push_back(d);
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask

  function automatic logic [31:0] cfg(input int md, src, dir, ext);
    return 32'(md) | (32'(src) << trig_qual_pkg::SRC_LSB)
         | (32'(dir) << trig_qual_pkg::EDGE_LSB)
         | (32'(dir) << trig_qual_pkg::PTYPE_LSB)
         | (32'(ext) << trig_qual_pkg::EXT_LSB);
  endfunction

  // Send a sample with a random stall before the next, noting a trigger
  task automatic put(input logic [31:0] a, input logic [31:0] ln,
                     input int src, input logic exp);
    if (exp) trig_q.push_back(sent);
    sent++;
    sample_source_inst.send(a, ln, src, $unsigned($random(seed)) % 3);
  endtask

  // Let the stream run dry, then no noted trigger may be left over
  task automatic drain(input string name);
    int t;
    t = 0;
    while (sample_source_inst.busy() && t < 1000) begin
      @(posedge hclk);
      t++;
    end
    repeat (8) @(posedge hclk);
    check(32'(trig_q.size()), 32'h0);
    trig_q.delete();
    $display("Test %s done", name);
  endtask

  // Monitor: triggers by sample index, read data in the data phase
  always @(posedge hclk) begin
    if (trig_event === 1'b1) begin
      if (trig_q.size() == 0) check({31'h0, trig_event}, 32'h0);
      else check(32'(idx - 1), 32'(trig_q.pop_front()));
    end
    if (sample.valid === 1'b1) idx++;
    if (rd_pend && hreadyout === 1'b1) check(hrdata, rd_q.pop_front());
    if (hreadyout === 1'b1) rd_pend = hsel && htrans[1] && !hwrite;
  end

  // Watchdog well beyond the expected run length
  initial begin
    #400000;
    errors++;
    $display("[FAIL] %0t: timeout", $time);
    end_sim();
  end

  initial begin
    {hclk, hsel, hwrite, htrans, haddr, hwdata, ext_pins} = '0;
    hsize = 3'b010;
    clk_en = 1'b1;
    hresetn = 1'b0;
    {errors, n_tests, sent, idx, rd_pend} = '0;
    seed = 99;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset values, unmapped offset, read back
    bus(0, trig_qual_pkg::CTRL_OFF, trig_qual_pkg::CTRL_RST);
    bus(0, trig_qual_pkg::MASK_OFF, trig_qual_pkg::MASK_RST);
    bus(0, 8'h2c, 32'h0);
    bus(1, trig_qual_pkg::LEVEL_OFF, 32'd50);
    bus(0, trig_qual_pkg::LEVEL_OFF, 32'd50);
    bus(1, trig_qual_pkg::HYST_OFF, 32'd10);
    // Continuous: every sample triggers, stalls in between
    for (int i = 0; i < 6; i++) put(i, 0, 0, 1'b1);
    drain("continuous");
    // Hold-off of two with interrupt status and mask
    bus(1, trig_qual_pkg::IRQ_MASK_OFF, 32'h1);
    bus(1, trig_qual_pkg::HOLD_OFF, 32'd2);
    for (int i = 0; i < 7; i++) put(i, 0, 0, (i % 3) == 0);
    drain("hold-off");
    bus(0, trig_qual_pkg::IRQ_STAT_OFF, 32'h3);
    check({31'h0, irq}, 32'h1);
    bus(1, trig_qual_pkg::IRQ_STAT_OFF, 32'h1);
    bus(0, trig_qual_pkg::IRQ_STAT_OFF, 32'h2);
    check({31'h0, irq}, 32'h0);
    bus(1, trig_qual_pkg::IRQ_MASK_OFF, 32'h2);
    repeat (2) @(posedge hclk);
    check({31'h0, irq}, 32'h1);
    bus(1, trig_qual_pkg::IRQ_STAT_OFF, 32'h2);
    bus(1, trig_qual_pkg::HOLD_OFF, 32'h0);
    check({31'h0, irq}, 32'h0);
    // Digital match on single lines, then random reference and mask
    bus(1, trig_qual_pkg::CTRL_OFF, cfg(2, 0, 0, 0));
    for (int j = 0; j < 3; j++) begin
      b = (j == 0) ? 32'h1 : (j == 1) ? 32'h2 : $random(seed);
      m = (j == 2) ? ($random(seed) | 32'h1) : b;
      bus(1, trig_qual_pkg::BITS_OFF, b);
      bus(1, trig_qual_pkg::MASK_OFF, m);
      put(0, ~b, 0, 1'b0);
      prev = 1'b0;
      for (int i = 0; i < 12; i++) begin
        l = (i % 3) ? ((b & m) | ($random(seed) & ~m)) : $random(seed);
        mt = ((l & m) == (b & m));
        put(0, l, 0, mt && !prev);
        prev = mt;
      end
      drain("digital");
    end
    // Edge crossings per direction, each on its own source
    for (int d = 0; d < 3; d++) begin
      bus(1, trig_qual_pkg::CTRL_OFF, cfg(1, d + 1, d, 0));
      for (int i = 0; i < 6; i++) begin
        put(seq[d][i], $random(seed), d + 1, hit[d][i]);
      end
      drain("edge");
    end
    // Pulse width window, positive then negative
    bus(1, trig_qual_pkg::PMIN_OFF, 32'd3);
    bus(1, trig_qual_pkg::PMAX_OFF, 32'd5);
    for (int p = 0; p < 2; p++) begin
      bus(1, trig_qual_pkg::CTRL_OFF, cfg(3, 0, p, 0));
      for (int w = 0; w < 3; w++) begin
        repeat (2) put(p ? 100 : 0, 0, 0, 1'b0);
        repeat (wd[w]) put(p ? 0 : 100, 0, 0, 1'b0);
        put(p ? 100 : 0, 0, 0, wd[w] == 4);
      end
      drain("pulse");
    end
    // Tracking edge: with shift 0 the level rides on the last sample
    bus(1, trig_qual_pkg::CTRL_OFF, cfg(4, 0, 0, 0));
    for (int i = 0; i < 6; i++) begin
      put((i == 5) ? 200 : (i > 1) ? 100 : 0, 0, 0, i == 2 || i == 5);
    end
    drain("tracking");
    // External inputs: only the selected one triggers
    for (int s = 0; s < 4; s++) begin
      bus(1, trig_qual_pkg::CTRL_OFF, cfg(6, 0, 0, s));
      @(posedge hclk);
      ext_pins <= 4'h1 << ((s + 1) % 4);
      repeat (8) @(posedge hclk);
      ext_pins <= 4'h0;
      repeat (8) @(posedge hclk);
      trig_q.push_back(sent - 1);
      ext_pins <= 4'h1 << s;
      repeat (8) @(posedge hclk);
      check({31'h0, ext_state}, 32'h1);
      ext_pins <= 4'h0;
      repeat (8) @(posedge hclk);
      check({31'h0, ext_state}, 32'h0);
      drain("external");
    end
    end_sim();
  end
endmodule
